// file: rtl/axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"
module axil_slave #(
   parameter AW = 9
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire [AW-1:0] awaddr_in,
   input wire awvalid_in,
   output wire awready_out,
   input wire [31:0] wdata_in,
   input wire [3:0] wstrb_in,
   input wire wvalid_in,
   output wire wready_out,
   output wire [1:0] bresp_out,
   output wire bvalid_out,
   input wire bready_in,
   input wire [AW-1:0] araddr_in,
   input wire arvalid_in,
   output wire arready_out,
   output wire [31:0] rdata_out,
   output wire [1:0] rresp_out,
   output wire rvalid_out,
   input wire rready_in,
   output wire wr_en_out,
   output wire [AW-1:0] wr_addr_out,
   output wire [31:0] wr_data_out,
   output wire [3:0] wr_strb_out,
   input wire wr_err_in,
   output wire [AW-1:0] rd_addr_out,
   input wire [31:0] rd_data_in,
   input wire rd_err_in
);
   reg aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   reg awready_q, wready_q, arready_q;
   reg [AW-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [1:0] bresp_q, rresp_q;
   reg [31:0] rdata_q;
   wire wr_fire = aw_hold_q & w_hold_q;
   wire aw_take = awvalid_in & awready_q;
   wire w_take = wvalid_in & wready_q;
   wire ar_take = arvalid_in & arready_q;
   wire aw_hold_d = aw_hold_q ? ~wr_fire : aw_take;
   wire w_hold_d = w_hold_q ? ~wr_fire : w_take;
   wire bvalid_d = wr_fire | (bvalid_q & ~bready_in);
   wire rvalid_d = ar_take | (rvalid_q & ~rready_in);

   // ready flops look one cycle ahead so they stay registered outputs
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         arready_q <= 1'b0;
         awaddr_q <= {AW{1'b0}};
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= `RESP_OKAY;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         bvalid_q <= bvalid_d;
         rvalid_q <= rvalid_d;
         awready_q <= ~aw_hold_d & ~bvalid_d;
         wready_q <= ~w_hold_d & ~bvalid_d;
         arready_q <= ~rvalid_d;
         if (aw_take) begin
            awaddr_q <= awaddr_in;
         end
         if (w_take) begin
            wdata_q <= wdata_in;
            wstrb_q <= wstrb_in;
         end
         if (wr_fire) begin
            bresp_q <= wr_err_in ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (ar_take) begin
            rdata_q <= rd_err_in ? 32'h0000_0000 : rd_data_in;
            rresp_q <= rd_err_in ? `RESP_SLVERR : `RESP_OKAY;
         end
      end
   end

   assign awready_out = awready_q;
   assign wready_out = wready_q;
   assign bvalid_out = bvalid_q;
   assign bresp_out = bresp_q;
   assign arready_out = arready_q;
   assign rvalid_out = rvalid_q;
   assign rresp_out = rresp_q;
   assign rdata_out = rdata_q;
   assign wr_en_out = wr_fire;
   assign wr_addr_out = awaddr_q;
   assign wr_data_out = wdata_q;
   assign wr_strb_out = wstrb_q;
   assign rd_addr_out = araddr_in;
endmodule
`default_nettype wire

// file: rtl/gpio_port_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"
module gpio_port_ctrl #(
   parameter NPORT = 6,
   parameter PW = 16,
   parameter LAST_PW = 4,
   parameter AW = 9
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire [AW-1:0] awaddr_in,
   input wire awvalid_in,
   output wire awready_out,
   input wire [31:0] wdata_in,
   input wire [3:0] wstrb_in,
   input wire wvalid_in,
   output wire wready_out,
   output wire [1:0] bresp_out,
   output wire bvalid_out,
   input wire bready_in,
   input wire [AW-1:0] araddr_in,
   input wire arvalid_in,
   output wire arready_out,
   output wire [31:0] rdata_out,
   output wire [1:0] rresp_out,
   output wire rvalid_out,
   input wire rready_in,
   input wire [31:0] boot_option_word_in,
   input wire [NPORT*PW-1:0] pin_in,
   output wire [NPORT*PW-1:0] pin_data_out,
   output wire [NPORT*PW-1:0] pin_oe_out,
   output wire [NPORT*PW-1:0] pull_up_en_out,
   output wire [NPORT*PW-1:0] input_buffer_type_select_out,
   output wire irq_out,
   output wire wakeup_out
);
   localparam NP = NPORT * PW;
   // last port only implements its low LAST_PW pins
   localparam [NP-1:0] IMPL = {{(PW-LAST_PW){1'b0}}, {LAST_PW{1'b1}},
                               {((NPORT-1)*PW){1'b1}}};

   reg [31:0] mode_q [0:NPORT-1];
   reg [PW-1:0] dout_q [0:NPORT-1];
   reg [PW-1:0] type_q [0:NPORT-1];
   reg [PW-1:0] imd_q [0:NPORT-1];
   reg [31:0] ien_q [0:NPORT-1];
   reg [PW-1:0] ists_q [0:NPORT-1];
   reg [PW-1:0] imask_q [0:NPORT-1];
   reg boot_meta_q, boot_sync_q;
   reg [NP-1:0] drv_q, oe_q, pu_q, type_out_q;
   reg irq_q, wake_q;

   wire wr_en;
   wire [AW-1:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [AW-1:0] rd_addr;
   reg [31:0] rd_data;
   reg rd_err;
   wire [NP-1:0] lvl, rise, fall;
   wire [NP-1:0] drv_d, oe_d, pu_d, ev;
   wire [NP-1:0] ists_flat, imask_flat, type_flat;

   wire [AW-1:`PORT_STRIDE_SHIFT] wr_port = wr_addr[AW-1:`PORT_STRIDE_SHIFT];
   wire [5:0] wr_ofs = wr_addr[5:0];
   wire [AW-1:`PORT_STRIDE_SHIFT] rd_port = rd_addr[AW-1:`PORT_STRIDE_SHIFT];
   wire [5:0] rd_ofs = rd_addr[5:0];
   wire wr_err = (wr_port >= NPORT) || (wr_ofs[1:0] != 2'h0) ||
                 (wr_ofs > `OFS_IMASK) || (wr_ofs == `OFS_PIN);

   axil_slave #(
      .AW(AW)
   ) bus (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .awaddr_in(awaddr_in),
      .awvalid_in(awvalid_in),
      .awready_out(awready_out),
      .wdata_in(wdata_in),
      .wstrb_in(wstrb_in),
      .wvalid_in(wvalid_in),
      .wready_out(wready_out),
      .bresp_out(bresp_out),
      .bvalid_out(bvalid_out),
      .bready_in(bready_in),
      .araddr_in(araddr_in),
      .arvalid_in(arvalid_in),
      .arready_out(arready_out),
      .rdata_out(rdata_out),
      .rresp_out(rresp_out),
      .rvalid_out(rvalid_out),
      .rready_in(rready_in),
      .wr_en_out(wr_en),
      .wr_addr_out(wr_addr),
      .wr_data_out(wr_data),
      .wr_strb_out(wr_strb),
      .wr_err_in(wr_err),
      .rd_addr_out(rd_addr),
      .rd_data_in(rd_data),
      .rd_err_in(rd_err)
   );

   pin_sampler #(
      .W(NP)
   ) sampler (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .raw_in(pin_in),
      .level_out(lvl),
      .rise_out(rise),
      .fall_out(fall)
   );

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            merge[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
         end
      end
   endfunction

   // byte-lane merge sized for the 16-bit registers, so nothing is cut
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] nw;
      input [1:0] strb;
      integer k;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            merge16[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
         end
      end
   endfunction

   function [31:0] widen2;
      input [15:0] m;
      integer k;
      begin
         for (k = 0; k < 16; k = k + 1) begin
            widen2[2*k +: 2] = {m[k], m[k]};
         end
      end
   endfunction

   // strap is a pin: two flops before reset logic uses it
   always @(posedge sys_clk_in) begin
      boot_meta_q <= boot_option_word_in[`BOOT_MODE_BIT];
      boot_sync_q <= boot_meta_q;
   end

   integer p;
   always @(posedge sys_clk_in) begin
      for (p = 0; p < NPORT; p = p + 1) begin
         if (rst_in) begin
            if (boot_sync_q) begin
               mode_q[p] <= `RST_MODE_QUASI & widen2(IMPL[p*PW +: PW]);
            end else begin
               mode_q[p] <= `RST_ZERO32;
            end
            dout_q[p] <= `RST_DOUT & IMPL[p*PW +: PW];
            type_q[p] <= `RST_ZERO16;
            imd_q[p] <= `RST_ZERO16;
            ien_q[p] <= `RST_ZERO32;
            ists_q[p] <= `RST_ZERO16;
            imask_q[p] <= `RST_ZERO16;
         end else begin
            // new events win over a write-one-to-clear in the same cycle
            ists_q[p] <= ists_q[p] | ev[p*PW +: PW];
            if (wr_en && !wr_err && wr_port == p) begin
               case (wr_ofs)
                  `OFS_MODE: begin
                     mode_q[p] <= merge(mode_q[p], wr_data, wr_strb) &
                                  widen2(IMPL[p*PW +: PW]);
                  end
                  `OFS_DOUT: begin
                     dout_q[p] <= merge16(dout_q[p], wr_data[15:0],
                                          wr_strb[1:0]) &
                                  IMPL[p*PW +: PW];
                  end
                  `OFS_MFP: begin
                     type_q[p] <= merge16(type_q[p], wr_data[`TYPE_LSB +: 16],
                                          wr_strb[3:2]);
                  end
                  `OFS_IMD: begin
                     imd_q[p] <= merge16(imd_q[p], wr_data[15:0],
                                         wr_strb[1:0]) & IMPL[p*PW +: PW];
                  end
                  `OFS_IEN: begin
                     ien_q[p] <= merge(ien_q[p], wr_data, wr_strb) &
                                 {IMPL[p*PW +: PW], IMPL[p*PW +: PW]};
                  end
                  `OFS_ISTS: begin
                     ists_q[p] <= (ists_q[p] &
                                   ~merge16(16'h0000, wr_data[15:0],
                                            wr_strb[1:0])) |
                                  ev[p*PW +: PW];
                  end
                  `OFS_IMASK: begin
                     imask_q[p] <= merge16(imask_q[p], wr_data[15:0],
                                           wr_strb[1:0]) & IMPL[p*PW +: PW];
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < NP; i = i + 1) begin : pin
         localparam integer P = i / PW;
         localparam integer B = i % PW;
         wire [1:0] md = mode_q[P][2*B +: 2];
         wire d = dout_q[P][B];
         wire lo_en = ien_q[P][B];
         wire hi_en = ien_q[P][PW+B];
         wire edge_ev = (rise[i] & hi_en) | (fall[i] & lo_en);
         wire lvl_ev = (lvl[i] & hi_en) | (~lvl[i] & lo_en);
         // open-drain and quasi only ever pull low
         assign drv_d[i] = (md == `MODE_PUSH_PULL) ? d : 1'b0;
         assign oe_d[i] = (md == `MODE_PUSH_PULL) ||
                          (((md == `MODE_OPEN_DRAIN) ||
                            (md == `MODE_QUASI)) && !d);
         assign pu_d[i] = (md == `MODE_QUASI);
         assign ev[i] = IMPL[i] & (imd_q[P][B] ? lvl_ev : edge_ev);
         assign ists_flat[i] = ists_q[P][B];
         assign imask_flat[i] = imask_q[P][B];
         assign type_flat[i] = type_q[P][B] & IMPL[i];
      end
   endgenerate

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         drv_q <= {NP{1'b0}};
         oe_q <= {NP{1'b0}};
         pu_q <= {NP{1'b0}};
         type_out_q <= {NP{1'b0}};
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         drv_q <= drv_d;
         oe_q <= oe_d;
         pu_q <= pu_d;
         type_out_q <= type_flat;
         irq_q <= |(ists_flat & imask_flat);
         // wake needs only the pin enable, not the interrupt mask
         wake_q <= |ists_flat;
      end
   end

   // read mux; the pin register is the synchronised level in every mode
   always @* begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (rd_port >= NPORT || rd_ofs[1:0] != 2'h0) begin
         rd_err = 1'b1;
      end else begin
         case (rd_ofs)
            `OFS_MODE: rd_data = mode_q[rd_port];
            `OFS_DOUT: rd_data = {16'h0000, dout_q[rd_port]};
            `OFS_PIN: rd_data = {16'h0000,
                                 lvl[rd_port*PW +: PW] &
                                 IMPL[rd_port*PW +: PW]};
            `OFS_MFP: rd_data = {type_q[rd_port] & IMPL[rd_port*PW +: PW],
                                 16'h0000};
            `OFS_IMD: rd_data = {16'h0000, imd_q[rd_port]};
            `OFS_IEN: rd_data = ien_q[rd_port];
            `OFS_ISTS: rd_data = {16'h0000, ists_q[rd_port]};
            `OFS_IMASK: rd_data = {16'h0000, imask_q[rd_port]};
            default: rd_err = 1'b1;
         endcase
      end
   end

   assign pin_data_out = drv_q;
   assign pin_oe_out = oe_q;
   assign pull_up_en_out = pu_q;
   assign input_buffer_type_select_out = type_out_q;
   assign irq_out = irq_q;
   assign wakeup_out = wake_q;
endmodule
`default_nettype wire

// file: rtl/gpio_regs.vh
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// per-port register block, byte offsets inside a 64-byte window
`define PORT_STRIDE_SHIFT 6
`define OFS_MODE 6'h00
`define OFS_DOUT 6'h04
`define OFS_PIN 6'h08
`define OFS_MFP 6'h0c
`define OFS_IMD 6'h10
`define OFS_IEN 6'h14
`define OFS_ISTS 6'h18
`define OFS_IMASK 6'h1c

// pin modes, two bits per pin in the mode register
`define MODE_INPUT 2'h0
`define MODE_PUSH_PULL 2'h1
`define MODE_OPEN_DRAIN 2'h2
`define MODE_QUASI 2'h3

// input buffer type field sits in the upper half of the mfp register
`define TYPE_LSB 16
`define BOOT_MODE_BIT 10

// reset values
`define RST_DOUT 16'hffff
`define RST_ZERO16 16'h0000
`define RST_ZERO32 32'h0000_0000
`define RST_MODE_QUASI 32'hffff_ffff

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/pin_sampler.v
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
   parameter W = 96
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire [W-1:0] raw_in,
   output wire [W-1:0] level_out,
   output wire [W-1:0] rise_out,
   output wire [W-1:0] fall_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   reg [W-1:0] prev_q;

   // meta_q feeds sync_q only; no reset so the chain needs no constant
   always @(posedge sys_clk_in) begin
      meta_q <= raw_in;
      sync_q <= meta_q;
   end

   // prev follows sync during reset as well, so no false edge at release
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         prev_q <= sync_q;
      end else begin
         prev_q <= sync_q;
      end
   end

   assign level_out = sync_q;
   assign rise_out = sync_q & ~prev_q;
   assign fall_out = ~sync_q & prev_q;
endmodule
`default_nettype wire

// file: test/general_purpose_io_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module general_purpose_io_port_test;
   localparam logic [95:0] pin_mask = {12'h0, {84{1'b1}}};
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [8:0] awaddr_in = '0, araddr_in = '0;
   logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
   logic arvalid_in = 1'b0, rready_in = 1'b0;
   logic [31:0] wdata_in = '0, boot_option_word_in = '0;
   logic [3:0] wstrb_in = 4'hf;
   logic [95:0] pin_in, ext_en = '0, ext_val = '0;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   logic irq_out, wakeup_out;
   logic [1:0] bresp_out, rresp_out;
   logic [31:0] rdata_out;
   logic [95:0] pin_data_out, pin_oe_out, pull_up_en_out;
   logic [95:0] input_buffer_type_select_out;
   int err_total = 0, tests_run = 0;
   gpio_port_ctrl dut (.*);
   pin_world far (.sys_clk_in(sys_clk_in), .oe_in(pin_oe_out),
      .data_in(pin_data_out), .pull_up_in(pull_up_en_out),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pin_in));
   initial begin
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      err_total++;
      $display("[ERR] %0t bus wait ran out", $time);
      end_of_test;
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         if (awready_out) awvalid_in <= 1'b0;
         if (wready_out) wvalid_in <= 1'b0;
         if (bvalid_out && bready_in) begin
            chk(bresp_out, er);
            bready_in <= 1'b0;
         end
         if (++n > 40) hang;
      end while (bready_in);
   endtask
   task automatic rd(input logic [8:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         if (arready_out) arvalid_in <= 1'b0;
         if (rvalid_out && rready_in) begin
            d = rdata_out;
            r = rresp_out;
            rready_in <= 1'b0;
         end
         if (++n > 40) hang;
      end while (rready_in);
   endtask
   task automatic rdc(input logic [8:0] a, input logic [31:0] e,
         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
      chk(r, er);
   endtask
   task automatic t_reset(input logic b);
      @(posedge sys_clk_in);
      boot_option_word_in <= {21'h0, b, 10'h0};
      rst_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      chk(pull_up_en_out & pin_mask, b ? pin_mask : '0);
      chk(pin_oe_out & pin_mask, '0);
      rdc(9'h080, b ? 32'hffff_ffff : 32'h0, 2'h0);
      rdc(9'h140, b ? 32'h0000_00ff : 32'h0, 2'h0);
      $display("reset test done, boot bit %0d", b);
   endtask
   task automatic t_modes;
      logic [31:0] d;
      logic [1:0] r;
      // outside pull-ups on pins 0 and 2 so released pads read high
      ext_en <= 96'h5;
      ext_val <= 96'h5;
      wr(9'h000, 32'h0000_00e4, 2'h0);
      for (int i = 0; i < 2; i++) begin
         wr(9'h004, i ? 32'hffff : 32'h0, 2'h0);
         repeat (4) @(posedge sys_clk_in);
         chk(pin_oe_out[3:0], i ? 4'h2 : 4'he);
         chk(pin_data_out[3:0], i ? 4'h2 : 4'h0);
         chk(pull_up_en_out[3:0], 4'h8);
         chk(pin_oe_out[83:4], '0);
         rd(9'h008, d, r);
         chk(d[3:0], i ? 4'hf : 4'h1);
      end
      ext_en <= '0;
      $display("pin mode test done");
   endtask
   task automatic t_type;
      wr(9'h04c, 32'ha5a5_1234, 2'h0);
      repeat (2) @(posedge sys_clk_in);
      chk(input_buffer_type_select_out[31:16], 16'ha5a5);
      rdc(9'h04c, 32'ha5a5_0000, 2'h0);
      $display("buffer type test done");
   endtask
   task automatic t_irq;
      ext_en <= 96'h20;
      ext_val <= 96'h20;
      wr(9'h010, 32'h0, 2'h0);
      wr(9'h014, 32'h20, 2'h0);
      wr(9'h01c, 32'h20, 2'h0);
      wr(9'h018, 32'hffff, 2'h0);
      ext_val <= '0;
      repeat (5) @(posedge sys_clk_in);
      chk({irq_out, wakeup_out}, 2'h3);
      rdc(9'h018, 32'h20, 2'h0);
      wr(9'h018, 32'h20, 2'h0);
      wr(9'h01c, 32'h0, 2'h0);
      ext_val <= 96'h20;
      repeat (5) @(posedge sys_clk_in);
      chk({irq_out, wakeup_out}, 2'h0);
      ext_val <= '0;
      repeat (5) @(posedge sys_clk_in);
      chk({irq_out, wakeup_out}, 2'h1);
      // rising edge enable lives in the upper half of the enable word
      wr(9'h014, 32'h0020_0000, 2'h0);
      wr(9'h018, 32'h20, 2'h0);
      ext_val <= 96'h20;
      repeat (5) @(posedge sys_clk_in);
      rdc(9'h018, 32'h20, 2'h0);
      // level mode: a held pin sets the status again after clearing
      wr(9'h010, 32'h20, 2'h0);
      wr(9'h018, 32'h20, 2'h0);
      rdc(9'h018, 32'h20, 2'h0);
      ext_val <= '0;
      wr(9'h014, 32'h20, 2'h0);
      wr(9'h018, 32'h20, 2'h0);
      rdc(9'h018, 32'h20, 2'h0);
      wr(9'h014, 32'h0, 2'h0);
      wr(9'h018, 32'hffff, 2'h0);
      ext_en <= '0;
      $display("interrupt test done");
   endtask
   task automatic t_bad;
      wr(9'h008, 32'h0, 2'h2);
      wr(9'h180, 32'h0, 2'h2);
      rdc(9'h020, 32'h0, 2'h2);
      rdc(9'h002, 32'h0, 2'h2);
      $display("refused access test done");
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_reset(1'b1);
      t_reset(1'b0);
      t_modes;
      t_type;
      t_irq;
      t_bad;
      end_of_test;
   end
endmodule
`default_nettype wire

// file: test/gpio_port_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_ctrl_chk #(
   parameter NPORT = 6,
   parameter PW = 16
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic awvalid_in,
   input wire logic awready_out,
   input wire logic wvalid_in,
   input wire logic wready_out,
   input wire logic [1:0] bresp_out,
   input wire logic bvalid_out,
   input wire logic bready_in,
   input wire logic arvalid_in,
   input wire logic arready_out,
   input wire logic [31:0] rdata_out,
   input wire logic rvalid_out,
   input wire logic rready_in,
   input wire logic [NPORT*PW-1:0] pin_data_out,
   input wire logic [NPORT*PW-1:0] pin_oe_out,
   input wire logic [NPORT*PW-1:0] pull_up_en_out,
   input wire logic irq_out,
   input wire logic wakeup_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   AST_PULL_NEVER_HIGH: assert property (
      (pull_up_en_out & pin_data_out) == '0) else $error("pull-up and high");
   AST_HIGH_NEEDS_OE: assert property (
      (pin_data_out & ~pin_oe_out) == '0) else $error("high without oe");
   AST_IRQ_WAKES: assert property (
      irq_out |-> wakeup_out) else $error("irq without wake-up");
   AST_RESET_NO_DRIVE: assert property (
      $fell(rst_in) |=> pin_oe_out == '0) else $error("pin driven at reset");
   AST_WR_ANSWER: assert property (
      awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out)
      else $error("write not answered");
   AST_RD_ANSWER: assert property (
      arvalid_in && arready_out |=> rvalid_out) else $error("read unanswered");
   AST_B_HOLD: assert property (
      bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
      else $error("write response dropped");
   AST_R_HOLD: assert property (
      rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
      else $error("read data dropped");
   AST_BUSY_NO_TAKE: assert property (
      bvalid_out |-> !awready_out && !wready_out) else $error("taken while busy");
endmodule
bind gpio_port_ctrl gpio_port_ctrl_chk #(.NPORT(NPORT), .PW(PW)) chk_i (.*);
`default_nettype wire

// file: test/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
module pin_world (
   input wire logic sys_clk_in,
   input wire logic [95:0] oe_in,
   input wire logic [95:0] data_in,
   input wire logic [95:0] pull_up_in,
   input wire logic [95:0] ext_en_in,
   input wire logic [95:0] ext_val_in,
   output logic [95:0] pad_out
);
   logic [95:0] last_q = '0;
   // a floating pad wanders, so it never keeps its old level
   always @(posedge sys_clk_in) begin
      last_q <= pad_out;
   end
   // device driver wins, then outside circuitry, then the weak pull-up
   assign pad_out = (oe_in & data_in) | (~oe_in & ext_en_in & ext_val_in)
      | (~oe_in & ~ext_en_in & (pull_up_in | ~last_q));
endmodule
`default_nettype wire
